// File: logic/phy_mii_mgmt_registers.sv
/*
 * Management register set of the two copper phys, reached over the serial
 * management pins: frame decoder, read shifter, write commit and the two
 * per-port register sets.
 * Assumes the management pins are synchronous to clk and that the
 * management clock is at most a quarter of the clk rate.
 */
// How it works
// - a frame is taken only for phy address 0x1 (port 1) or 0x2 (port 2).
// - index 0x1 is status, 0x2/0x3 identifier, 0x4 advert, 0x5 partner.
// - control bit 3 set turns auto crossover off; it resets to 0.
// - control bit 2 set suppresses far-end fault, port 1 only, reset 0.
// - control bit 1 stops the transmitter, bit 0 the LEDs; both reset 0.
// - status bit 15 always reads 0.
// - status bits 14..11 read 1111 and bits 10..7 read 0000.
// - status bits 6, 1 and 0 always read 0.
// - status bit 5 shows negotiation done, bit 2 link up; both reset 0.
// - status bit 4 shows a far-end fault, only on port 1.
// - status bit 3 follows the negotiation enable bit, reset 1.
// - indices 0x2 and 0x3 return fixed identifier words; writes ignored.
// - advert bit 10 is writable, resets 1; bits 15..11 read 0.
// - advert bits 8..5 writable, reset 1; bits 4..0 read 00001.
// - partner ability bits 15..13 read 0.
`timescale 1ns/1ns
`include "phy_mgmt_defs.svh"
module phy_mii_mgmt_registers #(
    parameter logic [15:0] IDENT_HIGH = 16'h5A01, // arbitrary value
    parameter logic [15:0] IDENT_LOW = 16'h7C10 // arbitrary value
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // management serial pins
    input wire logic mdc,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe,
    // switch side, index 0 is port 1
    input wire logic [1:0] sw_wr,
    input wire phy_mgmt_pkg::port_ctrl_type [1:0] sw_wdata,
    input wire phy_mgmt_pkg::port_stat_type [1:0] port_stat,
    output phy_mgmt_pkg::port_ctrl_type [1:0] port_ctrl
);

    phy_mgmt_pkg::frame_state_type state_q;
    logic rise;
    logic bit_v;
    logic [5:0] cnt_q;
    logic [11:0] hdr_q;
    logic [11:0] head_w;
    logic head_hit;
    logic is_rd_q;
    logic [15:0] shift_q;
    logic mdio_out_q;
    logic mdio_oe_q;
    logic [1:0] wr_pulse_q;
    logic [15:0] wr_data_q;
    logic port2_sel;
    logic [15:0] rd_word;
    logic [1:0][15:0] rdata;

    mdc_sampler u_sampler (
        .clk(clk),
        .reset_n(reset_n),
        .mdc(mdc),
        .mdio_in(mdio_in),
        .rise_q(rise),
        .bit_q(bit_v)
    );

    // header with the bit now arriving: op, phy address, register index
    assign head_w = {hdr_q[10:0], bit_v};
    assign head_hit = (head_w[9:5] == `PM_PORT1_ADDR ||
                       head_w[9:5] == `PM_PORT2_ADDR) &&
                      (head_w[11:10] == `PM_OP_RD ||
                       head_w[11:10] == `PM_OP_WR);
    assign port2_sel = hdr_q[9:5] == `PM_PORT2_ADDR;
    assign rd_word = port2_sel ? rdata[1] : rdata[0];

    // frame sequencer, stepping once per management clock rise
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= phy_mgmt_pkg::ST_IDLE;
            cnt_q <= 6'h00;
        end else if (rise) begin
            case (state_q)
                phy_mgmt_pkg::ST_IDLE: begin
                    if (bit_v) begin
                        if (cnt_q != `PM_PREAMBLE) begin
                            cnt_q <= cnt_q + 6'h01;
                        end
                    end else if (cnt_q == `PM_PREAMBLE) begin
                        state_q <= phy_mgmt_pkg::ST_START;
                        cnt_q <= 6'h00;
                    end else begin
                        cnt_q <= 6'h00;
                    end
                end
                phy_mgmt_pkg::ST_START: begin
                    state_q <= bit_v ? phy_mgmt_pkg::ST_HEAD
                                     : phy_mgmt_pkg::ST_IDLE;
                    cnt_q <= 6'h00;
                end
                phy_mgmt_pkg::ST_HEAD: begin
                    if (cnt_q == `PM_HEAD_LAST) begin
                        // frames for other phys are ignored whole
                        state_q <= head_hit ? phy_mgmt_pkg::ST_TURN
                                            : phy_mgmt_pkg::ST_IDLE;
                        cnt_q <= 6'h00;
                    end else begin
                        cnt_q <= cnt_q + 6'h01;
                    end
                end
                phy_mgmt_pkg::ST_TURN: begin
                    if (cnt_q == `PM_TURN_LAST) begin
                        state_q <= phy_mgmt_pkg::ST_DATA;
                        cnt_q <= 6'h00;
                    end else begin
                        cnt_q <= cnt_q + 6'h01;
                    end
                end
                phy_mgmt_pkg::ST_DATA: begin
                    if (cnt_q == `PM_DATA_LAST) begin
                        state_q <= phy_mgmt_pkg::ST_IDLE;
                        cnt_q <= 6'h00;
                    end else begin
                        cnt_q <= cnt_q + 6'h01;
                    end
                end
                default: begin
                    state_q <= phy_mgmt_pkg::ST_IDLE;
                    cnt_q <= 6'h00;
                end
            endcase
        end
    end

    // header capture; it stays put until the next frame's header
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            hdr_q <= 12'h000;
            is_rd_q <= 1'b0;
        end else if (rise && state_q == phy_mgmt_pkg::ST_HEAD) begin
            hdr_q <= head_w;
            if (cnt_q == `PM_HEAD_LAST) begin
                is_rd_q <= head_w[11:10] == `PM_OP_RD;
            end
        end
    end

    // pin driver: zero in the second turnaround bit, then data msb first;
    // the word is frozen at the turnaround so a read sees one snapshot
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mdio_out_q <= 1'b0;
            mdio_oe_q <= 1'b0;
            shift_q <= 16'h0000;
        end else if (rise) begin
            mdio_oe_q <= 1'b0;
            mdio_out_q <= 1'b0;
            if (state_q == phy_mgmt_pkg::ST_TURN && is_rd_q) begin
                mdio_oe_q <= 1'b1;
                if (cnt_q == `PM_TURN_LAST) begin
                    mdio_out_q <= rd_word[15];
                    shift_q <= {rd_word[14:0], 1'b0};
                end
            end else if (state_q == phy_mgmt_pkg::ST_DATA) begin
                if (is_rd_q && cnt_q != `PM_DATA_LAST) begin
                    mdio_oe_q <= 1'b1;
                    mdio_out_q <= shift_q[15];
                    shift_q <= {shift_q[14:0], 1'b0};
                end else if (!is_rd_q) begin
                    shift_q <= {shift_q[14:0], bit_v};
                end
            end
        end
    end

    assign mdio_out = mdio_out_q;
    assign mdio_oe = mdio_oe_q;

    // write commit after the last data bit
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_pulse_q <= 2'b00;
            wr_data_q <= 16'h0000;
        end else begin
            wr_pulse_q <= 2'b00;
            if (rise && state_q == phy_mgmt_pkg::ST_DATA && !is_rd_q &&
                cnt_q == `PM_DATA_LAST) begin
                wr_pulse_q <= {port2_sel, ~port2_sel};
                wr_data_q <= {shift_q[14:0], bit_v};
            end
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    sequence rd_turn_s;
        rise && state_q == phy_mgmt_pkg::ST_TURN && is_rd_q &&
            cnt_q == 6'h00;
    endsequence

    sequence rd_first_s;
        rise && state_q == phy_mgmt_pkg::ST_TURN && is_rd_q &&
            cnt_q == 6'h01;
    endsequence

    turn_drive_a: assert property (
        rd_turn_s |=> mdio_oe_q && !mdio_out_q
    ) else $error("read turnaround not driven low");

    first_bit_a: assert property (
        rd_first_s |=> mdio_oe_q && mdio_out_q == $past(rd_word[15])
    ) else $error("read msb not driven");

    write_quiet_a: assert property (
        state_q == phy_mgmt_pkg::ST_DATA && !is_rd_q |-> !mdio_oe_q
    ) else $error("pin driven during a write");

    phy_match_a: assert property (
        wr_pulse_q != 2'b00 |-> (hdr_q[9:5] == `PM_PORT2_ADDR) ==
            wr_pulse_q[1] && (wr_pulse_q[1] ||
            hdr_q[9:5] == `PM_PORT1_ADDR)
    ) else $error("write reached the wrong port");

    for (genvar p = 0; p < 2; p++) begin : g_port
        phy_port_regs #(
            .HAS_FEF(p == 0),
            .IDENT_HIGH(IDENT_HIGH),
            .IDENT_LOW(IDENT_LOW)
        ) u_regs (
            .clk(clk),
            .reset_n(reset_n),
            .phy_wr(wr_pulse_q[p]),
            .reg_idx(hdr_q[4:0]),
            .phy_wdata(wr_data_q),
            .rdata(rdata[p]),
            .sw_wr(sw_wr[p]),
            .sw_wdata(sw_wdata[p]),
            .stat_in(port_stat[p]),
            .ctrl_q(port_ctrl[p])
        );

        status_fixed_a: assert property (
            hdr_q[4:0] == `PM_IDX_STAT |->
                rdata[p][15:6] == 10'h1E0 && rdata[p][1:0] == 2'b00
        ) else $error("fixed status bits wrong");

        link_follow_a: assert property (
            hdr_q[4:0] == `PM_IDX_STAT |->
                rdata[p][2] == $past(port_stat[p].link_up) &&
                rdata[p][5] == $past(port_stat[p].an_done)
        ) else $error("link or negotiation status wrong");

        fault_gate_a: assert property (
            hdr_q[4:0] == `PM_IDX_STAT |-> rdata[p][4] ==
                (p == 0 && !port_ctrl[p].fef_off &&
                 $past(port_stat[p].far_fault))
        ) else $error("far-end fault bit wrong");

        an_able_a: assert property (
            hdr_q[4:0] == `PM_IDX_STAT |->
                rdata[p][3] == port_ctrl[p].an_enable
        ) else $error("negotiation ability bit wrong");

        ident_words_a: assert property (
            (hdr_q[4:0] == `PM_IDX_IDH |-> rdata[p] == IDENT_HIGH) and
            (hdr_q[4:0] == `PM_IDX_IDL |-> rdata[p] == IDENT_LOW)
        ) else $error("identifier word wrong");

        adv_fixed_a: assert property (
            hdr_q[4:0] == `PM_IDX_ADV |-> rdata[p][15:11] == 5'h00 &&
                rdata[p][4:0] == 5'h01 &&
                rdata[p][10] == port_ctrl[p].adv_pause &&
                rdata[p][8:5] == port_ctrl[p].adv
        ) else $error("advertisement word wrong");

        partner_top_a: assert property (
            hdr_q[4:0] == `PM_IDX_LPA |-> rdata[p][15:13] == 3'h0
        ) else $error("partner top bits not zero");

        fef_tie_a: assert property (
            p == 0 || !port_ctrl[p].fef_off
        ) else $error("far-end disable held on port 2");

        ctrl_write_a: assert property (
            wr_pulse_q[p] && hdr_q[4:0] == `PM_IDX_CTRL |=>
                port_ctrl[p].mdix_off == $past(wr_data_q[3]) &&
                port_ctrl[p].tx_off == $past(wr_data_q[1]) &&
                port_ctrl[p].led_off == $past(wr_data_q[0])
        ) else $error("control write not taken");

        switch_alias_a: assert property (
            sw_wr[p] && !wr_pulse_q[p] |=>
                port_ctrl[p].adv == $past(sw_wdata[p].adv) &&
                port_ctrl[p].mdix_off == $past(sw_wdata[p].mdix_off)
        ) else $error("switch write not seen");
    end

endmodule

// File: logic/phy_mgmt_defs.svh
/*
 * Constants of the PHY management register set: register indices, bit
 * positions, reset values and the serial frame layout.
 * Assumes it is included by the design files by bare name.
 */
`ifndef PHY_MGMT_DEFS_SVH
`define PHY_MGMT_DEFS_SVH

// phy select addresses of the two ports
`define PM_PORT1_ADDR 5'h01
`define PM_PORT2_ADDR 5'h02

// register indices inside one phy
`define PM_IDX_CTRL 5'h00
`define PM_IDX_STAT 5'h01
`define PM_IDX_IDH 5'h02
`define PM_IDX_IDL 5'h03
`define PM_IDX_ADV 5'h04
`define PM_IDX_LPA 5'h05

// basic control bit positions
`define PM_CTRL_AN_BIT 12
`define PM_CTRL_MDIX_BIT 3
`define PM_CTRL_FEF_BIT 2
`define PM_CTRL_TX_BIT 1
`define PM_CTRL_LED_BIT 0

// advertisement bit positions
`define PM_ADV_PAUSE_BIT 10
`define PM_ADV_ABIL_HI 8
`define PM_ADV_ABIL_LO 5

// fixed fields
`define PM_STAT_CAPS 4'hF
`define PM_SELECTOR 5'h01

// reset of the aliased control set: an on, disables off, pause and all
// four abilities advertised
`define PM_CTRL_RESET 10'h21F

// serial frame
`define PM_PREAMBLE 6'h20
`define PM_OP_RD 2'h2
`define PM_OP_WR 2'h1
`define PM_HEAD_LAST 6'h0B
`define PM_TURN_LAST 6'h01
`define PM_DATA_LAST 6'h0F

`endif

// File: logic/phy_mgmt_pkg.sv
/*
 * Types of the PHY management register set: control and status carriers
 * and the serial frame states.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package phy_mgmt_pkg;

    typedef struct packed {
        logic an_enable;
        logic mdix_off;
        logic fef_off;
        logic tx_off;
        logic led_off;
        logic adv_pause;
        logic [3:0] adv;
    } port_ctrl_type;

    typedef struct packed {
        logic link_up;
        logic an_done;
        logic far_fault;
        logic lp_pause;
        logic [3:0] lp_abil;
    } port_stat_type;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_START = 3'b001,
        ST_HEAD = 3'b010,
        ST_TURN = 3'b011,
        ST_DATA = 3'b100
    } frame_state_type;

endpackage

// File: logic/mdc_sampler.sv
/*
 * Samples the management clock and data pins and marks each rising edge
 * of the management clock with a one-cycle pulse.
 * Assumes both pins are synchronous to clk.
 */
`timescale 1ns/1ns
module mdc_sampler (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // pins
    input wire logic mdc,
    input wire logic mdio_in,
    // sampled view
    output logic rise_q,
    output logic bit_q
);

    logic mdc_q;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mdc_q <= 1'b0;
            rise_q <= 1'b0;
            bit_q <= 1'b0;
        end else begin
            mdc_q <= mdc;
            rise_q <= mdc & ~mdc_q;
            bit_q <= mdio_in;
        end
    end

endmodule

// File: logic/phy_port_regs.sv
/*
 * Register set of one phy: basic control, basic status, identifier words,
 * advertisement and partner ability, with the writable bits shared with
 * the switch's own per-port registers.
 * Assumes single-cycle write pulses and a stable register index.
 */
`timescale 1ns/1ns
`include "phy_mgmt_defs.svh"
module phy_port_regs #(
    parameter bit HAS_FEF = 1'b1,
    parameter logic [15:0] IDENT_HIGH = 16'h5A01, // arbitrary value
    parameter logic [15:0] IDENT_LOW = 16'h7C10 // arbitrary value
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // management side
    input wire logic phy_wr,
    input wire logic [4:0] reg_idx,
    input wire logic [15:0] phy_wdata,
    output logic [15:0] rdata,
    // switch side
    input wire logic sw_wr,
    input wire phy_mgmt_pkg::port_ctrl_type sw_wdata,
    input wire phy_mgmt_pkg::port_stat_type stat_in,
    output phy_mgmt_pkg::port_ctrl_type ctrl_q
);

    phy_mgmt_pkg::port_stat_type stat_q;
    logic fault_seen;

    // a management write lands after a switch write in the same cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_q <= phy_mgmt_pkg::port_ctrl_type'(`PM_CTRL_RESET);
        end else begin
            if (sw_wr) begin
                ctrl_q <= sw_wdata;
                ctrl_q.fef_off <= HAS_FEF & sw_wdata.fef_off;
            end
            if (phy_wr && reg_idx == `PM_IDX_CTRL) begin
                ctrl_q.an_enable <= phy_wdata[`PM_CTRL_AN_BIT];
                ctrl_q.mdix_off <= phy_wdata[`PM_CTRL_MDIX_BIT];
                ctrl_q.fef_off <= HAS_FEF & phy_wdata[`PM_CTRL_FEF_BIT];
                ctrl_q.tx_off <= phy_wdata[`PM_CTRL_TX_BIT];
                ctrl_q.led_off <= phy_wdata[`PM_CTRL_LED_BIT];
            end
            if (phy_wr && reg_idx == `PM_IDX_ADV) begin
                ctrl_q.adv_pause <= phy_wdata[`PM_ADV_PAUSE_BIT];
                ctrl_q.adv <= phy_wdata[`PM_ADV_ABIL_HI:`PM_ADV_ABIL_LO];
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stat_q <= '0;
        end else begin
            stat_q <= stat_in;
        end
    end

    // suppressed detection reports no fault
    assign fault_seen = HAS_FEF & ~ctrl_q.fef_off & stat_q.far_fault;

    // indices without a register read zero, identifiers ignore writes
    always_comb begin
        rdata = 16'h0000;
        case (reg_idx)
            `PM_IDX_CTRL: begin
                rdata[`PM_CTRL_AN_BIT] = ctrl_q.an_enable;
                rdata[`PM_CTRL_MDIX_BIT] = ctrl_q.mdix_off;
                rdata[`PM_CTRL_FEF_BIT] = ctrl_q.fef_off;
                rdata[`PM_CTRL_TX_BIT] = ctrl_q.tx_off;
                rdata[`PM_CTRL_LED_BIT] = ctrl_q.led_off;
            end
            `PM_IDX_STAT: begin
                rdata = {1'b0, `PM_STAT_CAPS, 4'h0, 1'b0, stat_q.an_done,
                         fault_seen, ctrl_q.an_enable, stat_q.link_up,
                         2'b00};
            end
            `PM_IDX_IDH: rdata = IDENT_HIGH;
            `PM_IDX_IDL: rdata = IDENT_LOW;
            `PM_IDX_ADV: begin
                rdata = {5'h00, ctrl_q.adv_pause, 1'b0, ctrl_q.adv,
                         `PM_SELECTOR};
            end
            `PM_IDX_LPA: begin
                rdata = {5'h00, stat_q.lp_pause, 1'b0, stat_q.lp_abil,
                         5'h00};
            end
            default: rdata = 16'h0000;
        endcase
    end

endmodule

// File: dv/mdio_master_model.sv
/*
 * Behavioural management-bus master: builds read and write frames on the
 * management clock and data pins and resolves the shared data wire.
 * Assumes the testbench calls frame() and that clk runs freely.
 */
`timescale 1ns/1ns
module mdio_master_model (
    // clock
    input wire logic clk,
    // pins
    output logic mdc,
    output logic mdio_in,
    input wire logic mdio_out,
    input wire logic mdio_oe
);
    logic m_en;
    logic m_val;

    // the wire carries a pull-up, so a released line reads 1
    assign mdio_in = m_en ? m_val : (mdio_oe ? mdio_out : 1'b1);

    initial begin
        mdc = 1'b0;
        m_en = 1'b0;
        m_val = 1'b0;
    end

    // three clk low, four high: longer than the minimum level time
    task automatic bitx(input logic drv, input logic b, output logic s);
        @(negedge clk);
        mdc = 1'b0;
        m_en = drv;
        m_val = b;
        repeat (3) @(negedge clk);
        s = mdio_in;
        mdc = 1'b1;
        repeat (3) @(negedge clk);
    endtask

    // the clock stands still low between frames
    task automatic frame(input logic [1:0] op, input logic [4:0] phy,
                         input logic [4:0] idx, input logic [15:0] wd,
                         output logic [15:0] rd);
        logic [13:0] head;
        logic s;
        int i;
        head = {2'b01, op, phy, idx};
        for (i = 0; i < 32; i++) begin
            bitx(1'b1, 1'b1, s);
        end
        for (i = 13; i >= 0; i--) begin
            bitx(1'b1, head[i], s);
        end
        for (i = 1; i >= 0; i--) begin
            bitx(op == 2'b01, i[0], s);
        end
        for (i = 15; i >= 0; i--) begin
            bitx(op == 2'b01, wd[i], s);
            rd[i] = s;
        end
        @(negedge clk);
        mdc = 1'b0;
        m_en = 1'b0;
        repeat (4) @(negedge clk);
    endtask
endmodule

// File: dv/tb_phy_mii_mgmt_registers.sv
/*
 * Self-checking testbench of the phy management register set: register
 * reads and writes over the serial pins, switch-side aliasing and reset.
 * Assumes the master model in mdio_master_model.sv.
 */
`timescale 1ns/1ns
module tb_phy_mii_mgmt_registers;
    localparam logic [15:0] ID_HI = 16'h5A01; // arbitrary value
    localparam logic [15:0] ID_LO = 16'h7C10; // arbitrary value
    logic clk;
    logic reset_n;
    logic mdc;
    logic mdio_in;
    logic mdio_out;
    logic mdio_oe;
    logic [1:0] sw_wr;
    phy_mgmt_pkg::port_ctrl_type [1:0] sw_wdata;
    phy_mgmt_pkg::port_stat_type [1:0] port_stat;
    phy_mgmt_pkg::port_ctrl_type [1:0] port_ctrl;
    int bad_count = 0;
    int n_checks = 0;
    logic [15:0] junk_word;

    phy_mii_mgmt_registers #(.IDENT_HIGH(ID_HI), .IDENT_LOW(ID_LO)) i_dut (
        .clk(clk), .reset_n(reset_n), .mdc(mdc), .mdio_in(mdio_in),
        .mdio_out(mdio_out), .mdio_oe(mdio_oe), .sw_wr(sw_wr),
        .sw_wdata(sw_wdata), .port_stat(port_stat), .port_ctrl(port_ctrl)
    );

    mdio_master_model i_mst (
        .clk(clk), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
        .mdio_oe(mdio_oe)
    );

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [4:0] phy, input logic [4:0] idx,
                      input logic [15:0] d);
        logic [15:0] r;
        i_mst.frame(2'h1, phy, idx, d, r);
    endtask

    task automatic rc(input logic [4:0] phy, input logic [4:0] idx,
                      input logic [15:0] exp);
        logic [15:0] r;
        i_mst.frame(2'h2, phy, idx, 16'h0000, r);
        chk(r, exp);
    endtask

    task automatic sw(input int p, input logic [9:0] v);
        @(negedge clk);
        sw_wr[p] = 1'b1;
        sw_wdata[p] = v;
        @(negedge clk);
        sw_wr[p] = 1'b0;
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // watchdog: the whole sequence needs far fewer cycles than this
    initial begin
        repeat (60000) @(posedge clk);
        bad_count++;
        $display("FAIL %0t run did not finish", $time);
        close_out();
    end

    initial begin
        reset_n = 1'b0;
        sw_wr = 2'h0;
        sw_wdata = '0;
        port_stat = '0;
        repeat (8) @(negedge clk);
        reset_n = 1'b1;
        chk({6'h00, port_ctrl[0]}, 16'h021F);
        chk({6'h00, port_ctrl[1]}, 16'h021F);
        rc(5'h01, 5'h00, 16'h1000);
        rc(5'h02, 5'h01, 16'h7808);
        rc(5'h01, 5'h02, ID_HI);
        rc(5'h01, 5'h03, ID_LO);
        wr(5'h02, 5'h02, 16'h0000);
        wr(5'h02, 5'h03, 16'hFFFF);
        rc(5'h02, 5'h02, ID_HI);
        rc(5'h02, 5'h03, ID_LO);
        rc(5'h01, 5'h04, 16'h05E1);
        rc(5'h02, 5'h05, 16'h0000);
        rc(5'h01, 5'h06, 16'h0000);
        rc(5'h01, 5'h1F, 16'h0000);
        // an unselected phy leaves the line to the pull-up
        rc(5'h03, 5'h01, 16'hFFFF);
        $display("test reset_and_map done");

        @(negedge clk);
        port_stat = {8'hFF, 8'hFF};
        rc(5'h01, 5'h01, 16'h783C);
        rc(5'h02, 5'h01, 16'h782C);
        rc(5'h01, 5'h05, 16'h05E0);
        wr(5'h01, 5'h05, 16'h0000);
        rc(5'h01, 5'h05, 16'h05E0);
        $display("test status done");

        wr(5'h01, 5'h00, 16'h100F);
        chk({6'h00, port_ctrl[0]}, 16'h03FF);
        rc(5'h01, 5'h00, 16'h100F);
        // suppressed far-end fault no longer shows in status
        rc(5'h01, 5'h01, 16'h782C);
        wr(5'h02, 5'h00, 16'h100F);
        chk({6'h00, port_ctrl[1]}, 16'h037F);
        rc(5'h02, 5'h00, 16'h100B);
        // a frame for another phy address changes nothing
        wr(5'h03, 5'h00, 16'h0000);
        chk({6'h00, port_ctrl[0]}, 16'h03FF);
        chk({6'h00, port_ctrl[1]}, 16'h037F);
        $display("test control done");

        wr(5'h01, 5'h04, 16'hFFFF);
        rc(5'h01, 5'h04, 16'h05E1);
        wr(5'h01, 5'h04, 16'h0000);
        rc(5'h01, 5'h04, 16'h0001);
        chk({6'h00, port_ctrl[0]}, 16'h03E0);
        // an unknown op code aborts the frame: no write, no answer
        i_mst.frame(2'h0, 5'h01, 5'h04, 16'h0000, junk_word);
        chk(junk_word, 16'hFFFF);
        chk({6'h00, port_ctrl[0]}, 16'h03E0);
        $display("test advert done");

        sw(0, 10'h01F);
        rc(5'h01, 5'h00, 16'h0000);
        rc(5'h01, 5'h04, 16'h05E1);
        rc(5'h01, 5'h01, 16'h7834);
        sw(1, 10'h3FF);
        chk({6'h00, port_ctrl[1]}, 16'h037F);
        // distinct status bits per port catch a swapped field
        @(negedge clk);
        port_stat = {8'h5A, 8'hA5};
        rc(5'h01, 5'h01, 16'h7814);
        rc(5'h02, 5'h01, 16'h7828);
        rc(5'h01, 5'h05, 16'h00A0);
        rc(5'h02, 5'h05, 16'h0540);
        $display("test alias done");

        @(negedge clk);
        reset_n = 1'b0;
        repeat (2) @(negedge clk);
        reset_n = 1'b1;
        chk({6'h00, port_ctrl[0]}, 16'h021F);
        chk({6'h00, port_ctrl[1]}, 16'h021F);
        rc(5'h01, 5'h00, 16'h1000);
        $display("test second_reset done");
        close_out();
    end
endmodule
